/* rtl/ssd_defs.vh */
`ifndef SSD_DEFS_VH
`define SSD_DEFS_VH
// Register byte offsets
`define SSD_OFS_CTRL 6'h00
`define SSD_OFS_RXH 6'h04
`define SSD_OFS_TXH 6'h08
`define SSD_OFS_RXS 6'h0c
`define SSD_OFS_TXS 6'h10
`define SSD_OFS_CMP0 6'h14
`define SSD_OFS_CMP1 6'h18
`define SSD_OFS_STAT 6'h1c
`define SSD_OFS_TCNT 6'h20
`define SSD_OFS_TNCNT 6'h24
`define SSD_OFS_RCNT 6'h28
`define SSD_OFS_RNCNT 6'h2c
// Control register fields
`define SSD_C_TX_ENABLED_STATE 0
`define SSD_C_RX_ENABLED_STATE 1
`define SSD_C_IDLE 2
`define SSD_C_PAYEN 3
`define SSD_C_EDGE 4
`define SSD_C_BASE 11:8
`define SSD_C_UPPER 15:12
`define SSD_C_WLEN 20:16
`define SSD_CTRL_RESET 32'h0007_0000
`define SSD_CTRL_MASK 32'h001f_ff1f
// Status register bits
`define SSD_S_TXFREE 0
`define SSD_S_TXDRAIN 1
`define SSD_S_TXCDONE 2
`define SSD_S_TXBDONE 3
`define SSD_S_RXAVAIL 4
`define SSD_S_OVR 5
`define SSD_S_RXCDONE 6
`define SSD_S_RXBDONE 7
`define SSD_S_CMP0 8
`define SSD_S_CMP1 9
`define SSD_S_TX_SYNC_EVENT 10
`define SSD_S_RX_SYNC_EVENT 11
`define SSD_S_TXON 16
`define SSD_S_RXON 17
// Sync data width and length arithmetic
`define SSD_SYNC_W 16
`define SSD_UPPER_SHIFT 4
`define SSD_EDGE_RISE 1'b0
`endif

/* rtl/ssd_sync2.v */
`timescale 1ns/1ps
module ssd_sync2 (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Asynchronous level in, synchronous level out
   input wire async_in,
   output reg sync_out
);
   reg meta;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta <= 1'b0;
         sync_out <= 1'b0;
      end else begin
         meta <= async_in;
         sync_out <= meta;
      end
   end
endmodule // ssd_sync2

/* rtl/ssd_serial_ctrl.v */
// Contract
// - Payload disabled: idle level during sync pulse
// - Payload enabled: shift sync word during pulse
// - Edge select picks tx sync flag edge
// - Upper length field extends base length
// - Data words held right-justified
// - Received sync word in bits 15:0, read-only
// - Transmit sync word read-write, bits 15:0
// - Compare value zero, 16-bit read-write
// - Compare value one, 16-bit read-write
// - Bit 0: transmit holding register empty
// - Bit 1: all written data shifted out
// - Bit 2: tx counter hit zero
// - Bit 4: received word waiting
// - Bit 5: overwrite of unread word, read-clear
// - Bit 6: rx counter hit zero
// - Bits 8,9: compare matches, read-clear
// - Bits 10,11: sync events, read-clear
// - Bits 16,17: transmitter, receiver enabled
// - Sync length base+16*upper+1 periods
// - Idle level on line outside transmission
// - Word is length field plus one bits; a zero field is run as a two-bit word
//
// The implementer's own choices: the Wishbone interface to the registers and the register offsets.
`timescale 1ns/1ps
`include "ssd_defs.vh"
module ssd_serial_ctrl #(
   parameter CNT_W = 16
) (
   // Clock and reset
   input wire clk,
   input wire rst_n,
   // Wishbone slave
   input wire wb_cyc_i,
   input wire wb_stb_i,
   input wire wb_we_i,
   input wire [7:0] wb_adr_i,
   input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i,
   output reg [31:0] wb_dat_o,
   output reg wb_ack_o,
   // Serial link
   input wire link_clk,
   input wire rx_data_pin,
   input wire rx_sync_pin,
   output reg serial_out_line,
   output reg tx_sync_pin
);
   localparam TX_IDLE = 2'd0;
   localparam TX_SYNC = 2'd1;
   localparam TX_DATA = 2'd2;
   localparam RX_IDLE = 2'd0;
   localparam RX_SYNC = 2'd1;
   localparam RX_DATA = 2'd2;

   reg [31:0] ctrl;
   reg [31:0] received_word;
   reg [31:0] outgoing_word;
   reg [15:0] received_sync_word;
   reg [15:0] outgoing_sync_word;
   reg [15:0] compare_zero;
   reg [15:0] compare_one;
   reg [CNT_W-1:0] tx_dma_counter;
   reg [CNT_W-1:0] tx_dma_next_counter;
   reg [CNT_W-1:0] rx_dma_counter;
   reg [CNT_W-1:0] rx_dma_next_counter;
   reg tx_holding_free;
   reg tx_dma_count_done;
   reg rx_word_available;
   reg rx_overwrite_flag;
   reg rx_dma_count_done;
   reg cmp0_flag;
   reg cmp1_flag;
   reg tx_sync_event;
   reg rx_sync_event;

   ////////////////////////////////////////////////////////////////////////////
   // Link inputs through two flip-flops
   wire lclk_s;
   wire rxd_s;
   wire rxs_s;
   reg lclk_q;

   ssd_sync2 u_sync_clk (.clk(clk), .rst_n(rst_n), .async_in(link_clk), .sync_out(lclk_s));
   ssd_sync2 u_sync_rxd (.clk(clk), .rst_n(rst_n), .async_in(rx_data_pin), .sync_out(rxd_s));
   ssd_sync2 u_sync_rxs (.clk(clk), .rst_n(rst_n), .async_in(rx_sync_pin), .sync_out(rxs_s));

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n)
         lclk_q <= 1'b0;
      else
         lclk_q <= lclk_s;
   end

   wire lclk_rise = lclk_s & ~lclk_q;
   wire lclk_fall = ~lclk_s & lclk_q;

   ////////////////////////////////////////////////////////////////////////////
   // Configuration decode
   wire tx_en = ctrl[`SSD_C_TX_ENABLED_STATE];
   wire rx_en = ctrl[`SSD_C_RX_ENABLED_STATE];
   wire idle_line_level = ctrl[`SSD_C_IDLE];
   wire sync_payload_enable = ctrl[`SSD_C_PAYEN];
   wire sync_edge_select = ctrl[`SSD_C_EDGE];
   wire [3:0] sync_length_base = ctrl[`SSD_C_BASE];
   wire [3:0] sync_length_upper = ctrl[`SSD_C_UPPER];
   wire [4:0] word_length_field = ctrl[`SSD_C_WLEN];
   // Zero is not a legal length; it is run as a two-bit word rather than hang
   wire [4:0] last_bit = (word_length_field == 5'h00) ? 5'h01 : word_length_field;
   wire [8:0] sync_periods = {5'h00, sync_length_base}
      + {1'b0, sync_length_upper, 4'h0} + 9'h001;

   ////////////////////////////////////////////////////////////////////////////
   // Wishbone decode; writes and read side effects act on the ack edge
   wire req = wb_cyc_i & wb_stb_i;
   wire acc = req & wb_ack_o;
   wire wr = acc & wb_we_i & in_map;
   wire rd = acc & ~wb_we_i & in_map;
   // Addresses above the register map decode to nothing rather than alias low
   wire in_map = (wb_adr_i[7:6] == 2'b00);
   wire [5:0] ofs = {wb_adr_i[5:2], 2'b00};
   wire [31:0] bmask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}}, {8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
   wire wr_ctrl = wr && (ofs == `SSD_OFS_CTRL);
   wire wr_txh = wr && (ofs == `SSD_OFS_TXH);
   wire wr_txs = wr && (ofs == `SSD_OFS_TXS);
   wire wr_cmp0 = wr && (ofs == `SSD_OFS_CMP0);
   wire wr_cmp1 = wr && (ofs == `SSD_OFS_CMP1);
   wire wr_tcnt = wr && (ofs == `SSD_OFS_TCNT);
   wire wr_tncnt = wr && (ofs == `SSD_OFS_TNCNT);
   wire wr_rcnt = wr && (ofs == `SSD_OFS_RCNT);
   wire wr_rncnt = wr && (ofs == `SSD_OFS_RNCNT);
   wire rd_rxh = rd && (ofs == `SSD_OFS_RXH);
   wire rd_stat = rd && (ofs == `SSD_OFS_STAT);

   function [31:0] merge;
      input [31:0] old;
      input [31:0] val;
      input [31:0] m;
      begin
         merge = (old & ~m) | (val & m);
      end
   endfunction

   wire [31:0] txs_merged = merge({16'h0000, outgoing_sync_word}, wb_dat_i, bmask);
   wire [31:0] cmp0_merged = merge({16'h0000, compare_zero}, wb_dat_i, bmask);
   wire [31:0] cmp1_merged = merge({16'h0000, compare_one}, wb_dat_i, bmask);

   ////////////////////////////////////////////////////////////////////////////
   // Transmitter
   reg [1:0] tx_state;
   reg [31:0] tx_shifter;
   reg [15:0] tx_sync_sh;
   reg [8:0] tx_sync_cnt;
   reg [4:0] tx_bit;
   wire tx_load = lclk_fall && tx_en && !tx_holding_free;
   wire tx_start = tx_load && ((tx_state == TX_IDLE) || (tx_state == TX_DATA && tx_bit == 5'h00));
   wire tx_sync_end = lclk_fall && (tx_state == TX_SYNC) && (tx_sync_cnt == 9'h001);
   wire tx_drained = (tx_state == TX_IDLE) && tx_holding_free;
   wire tx_sync_hit = (sync_edge_select == `SSD_EDGE_RISE) ? tx_start : tx_sync_end;
   wire tx_dec = wr_txh && (tx_dma_counter != {CNT_W{1'b0}});

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_state <= TX_IDLE;
         tx_shifter <= 32'h0000_0000;
         tx_sync_sh <= 16'h0000;
         tx_sync_cnt <= 9'h000;
         tx_bit <= 5'h00;
         serial_out_line <= 1'b0;
         tx_sync_pin <= 1'b0;
      end else begin
         case (tx_state)
            TX_IDLE: begin
               tx_sync_pin <= 1'b0;
               serial_out_line <= idle_line_level;
               if (tx_start) begin
                  tx_state <= TX_SYNC;
               end
            end
            TX_SYNC: begin
               if (lclk_fall) begin
                  if (tx_sync_cnt == 9'h001) begin
                     tx_state <= TX_DATA;
                     tx_sync_pin <= 1'b0;
                     serial_out_line <= tx_shifter[0];
                     tx_shifter <= tx_shifter >> 1;
                     tx_bit <= last_bit;
                  end else begin
                     tx_sync_cnt <= tx_sync_cnt - 9'h001;
                     // Past bit 15 the sync data is exhausted; idle level fills
                     serial_out_line <= sync_payload_enable ? tx_sync_sh[0]
                        : idle_line_level;
                     tx_sync_sh <= {idle_line_level, tx_sync_sh[15:1]};
                  end
               end
            end
            TX_DATA: begin
               if (lclk_fall) begin
                  if (tx_bit == 5'h01 || tx_bit == 5'h00) begin
                     if (tx_bit == 5'h00 && !tx_start) begin
                        tx_state <= TX_IDLE;
                        serial_out_line <= idle_line_level;
                     end else if (tx_bit == 5'h01) begin
                        serial_out_line <= tx_shifter[0];
                        tx_bit <= 5'h00;
                     end
                  end else begin
                     serial_out_line <= tx_shifter[0];
                     tx_shifter <= tx_shifter >> 1;
                     tx_bit <= tx_bit - 5'h01;
                  end
                  if (tx_start)
                     tx_state <= TX_SYNC;
               end
            end
            default: tx_state <= TX_IDLE;
         endcase
         if (tx_start) begin
            // First sync bit goes out at the same edge the pulse rises
            tx_shifter <= outgoing_word;
            tx_sync_pin <= 1'b1;
            tx_sync_cnt <= sync_periods;
            serial_out_line <= sync_payload_enable ? outgoing_sync_word[0]
               : idle_line_level;
            tx_sync_sh <= {idle_line_level, outgoing_sync_word[15:1]};
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Receiver, sampling on the link clock rising edge
   reg [1:0] rx_state;
   reg [4:0] rx_idx;
   reg [31:0] rx_sh;
   reg [15:0] rx_sync_sh;
   wire rx_sync_done = lclk_rise && rx_en && (rx_state == RX_SYNC) && !rxs_s;
   wire rx_word_done = lclk_rise && rx_en && (rx_state == RX_DATA) && (rx_idx == last_bit);
   wire [15:0] next_sync_word = rx_sync_sh;
   wire rx_dec = rd_rxh && (rx_dma_counter != {CNT_W{1'b0}});

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rx_state <= RX_IDLE;
         rx_idx <= 5'h00;
         rx_sh <= 32'h0000_0000;
         rx_sync_sh <= 16'h0000;
         received_word <= 32'h0000_0000;
         received_sync_word <= 16'h0000;
      end else if (!rx_en) begin
         rx_state <= RX_IDLE;
      end else if (lclk_rise) begin
         case (rx_state)
            RX_IDLE: begin
               if (rxs_s) begin
                  rx_state <= RX_SYNC;
                  rx_sync_sh <= {15'h0000, rxd_s};
                  rx_idx <= 5'h01;
               end
            end
            RX_SYNC: begin
               if (rxs_s) begin
                  if (rx_idx < `SSD_SYNC_W)
                     rx_sync_sh[rx_idx[3:0]] <= rxd_s;
                  if (rx_idx < `SSD_SYNC_W)
                     rx_idx <= rx_idx + 5'h01;
               end else begin
                  received_sync_word <= next_sync_word;
                  rx_sh <= {31'h0000_0000, rxd_s};
                  rx_idx <= 5'h01;
                  rx_state <= RX_DATA;
               end
            end
            RX_DATA: begin
               rx_sh[rx_idx] <= rxd_s;
               rx_idx <= rx_idx + 5'h01;
               if (rx_idx == last_bit) begin
                  // Bits fill from bit 0 upward, so the word lands right-justified
                  received_word <= rx_sh | ({31'h0000_0000, rxd_s} << rx_idx);
                  rx_state <= RX_IDLE;
               end
            end
            default: rx_state <= RX_IDLE;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Software registers and DMA counters
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctrl <= `SSD_CTRL_RESET;
         outgoing_word <= 32'h0000_0000;
         outgoing_sync_word <= 16'h0000;
         compare_zero <= 16'h0000;
         compare_one <= 16'h0000;
         tx_dma_counter <= {CNT_W{1'b0}};
         tx_dma_next_counter <= {CNT_W{1'b0}};
         rx_dma_counter <= {CNT_W{1'b0}};
         rx_dma_next_counter <= {CNT_W{1'b0}};
      end else begin
         if (wr_ctrl)
            ctrl <= merge(ctrl, wb_dat_i, bmask) & `SSD_CTRL_MASK;
         if (wr_txh)
            outgoing_word <= merge(outgoing_word, wb_dat_i, bmask);
         if (wr_txs)
            outgoing_sync_word <= txs_merged[15:0];
         if (wr_cmp0)
            compare_zero <= cmp0_merged[15:0];
         if (wr_cmp1)
            compare_one <= cmp1_merged[15:0];
         // Counters step once per holding-register access, standing in for DMA
         if (wr_tcnt)
            tx_dma_counter <= wb_dat_i[CNT_W-1:0];
         else if (tx_dec && tx_dma_counter == {{(CNT_W-1){1'b0}}, 1'b1}) begin
            tx_dma_counter <= tx_dma_next_counter;
            tx_dma_next_counter <= {CNT_W{1'b0}};
         end else if (tx_dec)
            tx_dma_counter <= tx_dma_counter - {{(CNT_W-1){1'b0}}, 1'b1};
         if (wr_tncnt)
            tx_dma_next_counter <= wb_dat_i[CNT_W-1:0];
         if (wr_rcnt)
            rx_dma_counter <= wb_dat_i[CNT_W-1:0];
         else if (rx_dec && rx_dma_counter == {{(CNT_W-1){1'b0}}, 1'b1}) begin
            rx_dma_counter <= rx_dma_next_counter;
            rx_dma_next_counter <= {CNT_W{1'b0}};
         end else if (rx_dec)
            rx_dma_counter <= rx_dma_counter - {{(CNT_W-1){1'b0}}, 1'b1};
         if (wr_rncnt)
            rx_dma_next_counter <= wb_dat_i[CNT_W-1:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Status flags; a hardware set wins (except tx_start, which loses to wr_txh), and a status read clears only the bits it returned,
   // so an event landing between capture and ack is not lost
   wire tx_cnt_hit = tx_dec && tx_dma_counter == {{(CNT_W-1){1'b0}}, 1'b1};
   wire rx_cnt_hit = rx_dec && rx_dma_counter == {{(CNT_W-1){1'b0}}, 1'b1};

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         tx_holding_free <= 1'b1;
         tx_dma_count_done <= 1'b0;
         rx_word_available <= 1'b0;
         rx_overwrite_flag <= 1'b0;
         rx_dma_count_done <= 1'b0;
         cmp0_flag <= 1'b0;
         cmp1_flag <= 1'b0;
         tx_sync_event <= 1'b0;
         rx_sync_event <= 1'b0;
      end else begin
         if (wr_txh)
            tx_holding_free <= 1'b0;
         else if (tx_start)
            tx_holding_free <= 1'b1;
         if (tx_cnt_hit)
            tx_dma_count_done <= 1'b1;
         else if (wr_tcnt || wr_tncnt)
            tx_dma_count_done <= 1'b0;
         if (rx_cnt_hit)
            rx_dma_count_done <= 1'b1;
         else if (wr_rcnt || wr_rncnt)
            rx_dma_count_done <= 1'b0;
         if (rx_word_done)
            rx_word_available <= 1'b1;
         else if (rd_rxh)
            rx_word_available <= 1'b0;
         // A word counts as unread if still flagged when the next one lands
         if (rx_word_done && rx_word_available && !rd_rxh)
            rx_overwrite_flag <= 1'b1;
         else if (rd_stat && wb_dat_o[`SSD_S_OVR])
            rx_overwrite_flag <= 1'b0;
         if (rx_sync_done && next_sync_word == compare_zero)
            cmp0_flag <= 1'b1;
         else if (rd_stat && wb_dat_o[`SSD_S_CMP0])
            cmp0_flag <= 1'b0;
         if (rx_sync_done && next_sync_word == compare_one)
            cmp1_flag <= 1'b1;
         else if (rd_stat && wb_dat_o[`SSD_S_CMP1])
            cmp1_flag <= 1'b0;
         if (tx_sync_hit)
            tx_sync_event <= 1'b1;
         else if (rd_stat && wb_dat_o[`SSD_S_TX_SYNC_EVENT])
            tx_sync_event <= 1'b0;
         if (rx_sync_done)
            rx_sync_event <= 1'b1;
         else if (rd_stat && wb_dat_o[`SSD_S_RX_SYNC_EVENT])
            rx_sync_event <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux and ack
   reg [31:0] stat_word;
   reg [31:0] rd_mux;

   always @* begin
      stat_word = 32'h0000_0000;
      stat_word[`SSD_S_TXFREE] = tx_holding_free;
      stat_word[`SSD_S_TXDRAIN] = tx_drained;
      stat_word[`SSD_S_TXCDONE] = tx_dma_count_done;
      stat_word[`SSD_S_TXBDONE] = (tx_dma_counter == {CNT_W{1'b0}})
         && (tx_dma_next_counter == {CNT_W{1'b0}});
      stat_word[`SSD_S_RXAVAIL] = rx_word_available;
      stat_word[`SSD_S_OVR] = rx_overwrite_flag;
      stat_word[`SSD_S_RXCDONE] = rx_dma_count_done;
      stat_word[`SSD_S_RXBDONE] = (rx_dma_counter == {CNT_W{1'b0}})
         && (rx_dma_next_counter == {CNT_W{1'b0}});
      stat_word[`SSD_S_CMP0] = cmp0_flag;
      stat_word[`SSD_S_CMP1] = cmp1_flag;
      stat_word[`SSD_S_TX_SYNC_EVENT] = tx_sync_event;
      stat_word[`SSD_S_RX_SYNC_EVENT] = rx_sync_event;
      stat_word[`SSD_S_TXON] = tx_en;
      stat_word[`SSD_S_RXON] = rx_en;
   end

   always @* begin
      if (ofs == `SSD_OFS_CTRL)
         rd_mux = ctrl;
      else if (ofs == `SSD_OFS_RXH)
         rd_mux = received_word;
      else if (ofs == `SSD_OFS_RXS)
         rd_mux = {16'h0000, received_sync_word};
      else if (ofs == `SSD_OFS_TXS)
         rd_mux = {16'h0000, outgoing_sync_word};
      else if (ofs == `SSD_OFS_CMP0)
         rd_mux = {16'h0000, compare_zero};
      else if (ofs == `SSD_OFS_CMP1)
         rd_mux = {16'h0000, compare_one};
      else if (ofs == `SSD_OFS_STAT)
         rd_mux = stat_word;
      else if (ofs == `SSD_OFS_TCNT)
         rd_mux = {{(32-CNT_W){1'b0}}, tx_dma_counter};
      else if (ofs == `SSD_OFS_TNCNT)
         rd_mux = {{(32-CNT_W){1'b0}}, tx_dma_next_counter};
      else if (ofs == `SSD_OFS_RCNT)
         rd_mux = {{(32-CNT_W){1'b0}}, rx_dma_counter};
      else if (ofs == `SSD_OFS_RNCNT)
         rd_mux = {{(32-CNT_W){1'b0}}, rx_dma_next_counter};
      else
         rd_mux = 32'h0000_0000; // Transmit holding is write-only; unmapped reads zero
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_ack_o <= req & ~wb_ack_o;
         if (req & ~wb_ack_o & ~wb_we_i)
            wb_dat_o <= in_map ? rd_mux : 32'h0000_0000;
      end
   end
endmodule // ssd_serial_ctrl

/* tb/ssd_serial_ctrl_checker.sv */
`timescale 1ns/1ps
`include "ssd_defs.vh"
module ssd_serial_ctrl_checker #(
   parameter LDIV = 8
) (
   // Clock, reset and bus
   input wire clk, input wire rst_n, input wire wb_cyc_i, input wire wb_stb_i,
   input wire wb_we_i, input wire [7:0] wb_adr_i, input wire [3:0] wb_sel_i,
   input wire [31:0] wb_dat_i, input wire [31:0] wb_dat_o, input wire wb_ack_o,
   // Serial link
   input wire link_clk, input wire rx_data_pin, input wire rx_sync_pin,
   input wire serial_out_line, input wire tx_sync_pin
);
   localparam [11:0] LD = LDIV;
   reg [15:0] ctl;
   reg [11:0] hc;
   wire [7:0] a = {wb_adr_i[7:2], 2'b00};
   wire wr = wb_ack_o & wb_cyc_i & wb_stb_i & wb_we_i;
   wire rd = wb_ack_o & wb_cyc_i & wb_stb_i & !wb_we_i;
   wire st = rd && a == {2'b00, `SSD_OFS_STAT};
   wire [11:0] len = ({4'h0, ctl[15:8]} + 12'h1) * LD;
   // Shadow of the control bits; the bench always writes all bytes
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         ctl <= 16'h0;
         hc <= 12'h0;
      end else begin
         if (wr && a == {2'b00, `SSD_OFS_CTRL})
            ctl <= wb_dat_i[15:0];
         hc <= tx_sync_pin ? hc + 12'h1 : 12'h0;
      end
   end
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_n);
   ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_prompt_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack not one cycle after request");
   sync_quiet_a: assert property (tx_sync_pin && !ctl[3] |-> serial_out_line == ctl[2])
      else $error("line not idle during sync pulse");
   no_start_a: assert property (!ctl[0] |-> !$rose(tx_sync_pin))
      else $error("frame started while disabled");
   stat_en_a: assert property (st |-> wb_dat_o[17:16] == ctl[1:0])
      else $error("enable bits wrong in status");
   stat_zero_a: assert property (st |-> wb_dat_o[31:18] == 14'h0 && wb_dat_o[15:12] == 4'h0)
      else $error("unused status bits set");
   sync_upper_a: assert property (rd && a >= 8'h0c && a <= 8'h18 |-> wb_dat_o[31:16] == 16'h0)
      else $error("upper bits of sync or compare set");
   sync_len_a: assert property ($fell(tx_sync_pin) |-> hc + 12'h1 >= len && hc <= len + 12'h1)
      else $error("sync pulse length wrong");
   cover property ($rose(tx_sync_pin));
   cover property (st && wb_dat_o[5]);
   cover property (st && wb_dat_o[8]);
endmodule // ssd_serial_ctrl_checker
bind ssd_serial_ctrl ssd_serial_ctrl_checker i_chk (.clk(clk), .rst_n(rst_n),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
   .link_clk(link_clk), .rx_data_pin(rx_data_pin), .rx_sync_pin(rx_sync_pin),
   .serial_out_line(serial_out_line), .tx_sync_pin(tx_sync_pin));

/* tb/ssd_peer_model.sv */
`timescale 1ns/1ps
module ssd_peer_model (
   // Lines towards the block
   output logic link_clk,
   output logic rx_data_pin,
   output logic rx_sync_pin,
   // Lines from the block
   input wire logic serial_out_line,
   input wire logic tx_sync_pin
);
   bit run;
   bit got;
   logic [1:0] q[$];
   // Clock stands low between frames
   initial begin
      link_clk = 0;
      rx_sync_pin = 0;
      rx_data_pin = 0;
      #7;
      forever begin
         #160;
         link_clk = run ? ~link_clk : 1'b0;
      end
   end
   // Sampled at the falling edge, far from where the block changes the line
   always @(negedge link_clk) begin
      if (tx_sync_pin || got) begin
         q.push_back({tx_sync_pin, serial_out_line});
         got = 1;
      end
   end
   task automatic send(input logic [15:0] s, input logic [7:0] d);
      for (int i = 0; i < 24; i++) begin
         @(negedge link_clk);
         rx_sync_pin = i < 16;
         rx_data_pin = i < 16 ? s[i] : d[i-16];
      end
      @(negedge link_clk);
      rx_sync_pin = 0;
      rx_data_pin = ~rx_data_pin;
   endtask
endmodule // ssd_peer_model

/* tb/ssd_serial_ctrl_tb.sv */
`timescale 1ns/1ps
module ssd_serial_ctrl_tb;
   logic clk, rst_n, cyc, stb, we;
   logic [7:0] adr;
   logic [31:0] dat, q, v, w, gs, gd;
   wire [31:0] dat_o;
   wire ack, lclk, rxd, rxs, sol, tsp;
   int fails, checks_done, seed, i;
   ssd_serial_ctrl i_dut (.clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat), .wb_dat_o(dat_o),
      .wb_ack_o(ack), .link_clk(lclk), .rx_data_pin(rxd), .rx_sync_pin(rxs),
      .serial_out_line(sol), .tx_sync_pin(tsp));
   ssd_peer_model i_peer (.link_clk(lclk), .rx_data_pin(rxd), .rx_sync_pin(rxs),
      .serial_out_line(sol), .tx_sync_pin(tsp));
   initial begin
      clk = 0;
      forever #20 clk = ~clk;
   end
   ////////////////////////////////////////////////////////////////////////////////
   task conclude;
      $display("checks %0d fails %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   task chk(input logic [31:0] s, input logic [31:0] e);
      checks_done++;
      if (s !== e) begin
         fails++;
         $display("[ERR] %0t seen %h exp %h", $time, s, e);
      end
   endtask
   // Ack is read in the active region, so it is the value of the ending cycle
   // Only the watchdog ends a wait for ack
   task wb(input logic w_, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      cyc <= 1;
      stb <= 1;
      we <= w_;
      adr <= a;
      dat <= d;
      do begin
         @(posedge clk);
      end while (ack !== 1'b1);
      q = dat_o;
      cyc <= 0;
      stb <= 0;
   endtask
   task rd(input logic [7:0] a, input logic [31:0] e);
      wb(0, a, 0);
      chk(q, e);
   endtask
   task txf(input logic [31:0] c);
      int k, m, ln, wd, ns;
      logic [15:0] s;
      logic [7:0] d;
      s = $random(seed);
      d = $random(seed);
      ln = c[11:8] + 16 * c[15:12] + 1;
      wd = c[20:16] + 1;
      wb(1, 8'h00, c);
      wb(1, 8'h10, {16'h0, s});
      i_peer.q.delete();
      i_peer.got = 0;
      wb(1, 8'h08, {24'h0, d});
      wb(0, 8'h1c, 0);
      chk(q[1:0], 2'b00);
      i_peer.run = 1;
      m = 0;
      while (i_peer.q.size() < ln + wd + 1) begin
         @(posedge clk);
         if (i_peer.q.size() == 3 && m == 0) begin
            m = 1;
            wb(0, 8'h1c, 0);
            chk(q[10], !c[4]);
         end
      end
      repeat (12) @(posedge clk);
      i_peer.run = 0;
      gs = 0;
      gd = 0;
      ns = 0;
      for (k = 0; k < ln + wd; k++) begin
         ns += i_peer.q[k][1];
         if (k < ln) gs[k] = i_peer.q[k][0];
         else gd[k-ln] = i_peer.q[k][0];
      end
      chk(ns, ln);
      chk(gs, c[3] ? s & ((1 << ln) - 1) : (c[2] ? (1 << ln) - 1 : 0));
      chk(gd, d & ((1 << wd) - 1));
      rd(8'h1c, 32'h0001_008b | {21'h0, c[4], 10'h0});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      #1_000_000;
      fails++;
      conclude;
   end
   initial begin
      seed = 32'hcd170c8d;
      {cyc, stb, we, adr, dat, fails, checks_done} = 0;
      rst_n = 0;
      repeat (16) @(posedge clk);
      rst_n <= 1;
      rd(8'h00, 32'h0007_0000);
      rd(8'h1c, 32'h0000_008b);
      for (i = 0; i < 3; i++) begin
         v = $random(seed);
         wb(1, 8'h10 + 8'(4 * i), v);
         rd(8'h10 + 8'(4 * i), v & 32'hffff);
      end
      wb(1, 8'h0c, v);
      rd(8'h0c, 0);
      wb(1, 8'h1c, 32'hffff_ffff);
      rd(8'h1c, 32'h0000_008b);
      rd(8'h40, 0);
      $display("registers done");
      txf(32'h0007_050d);
      txf(32'h0003_1015);
      $display("transmit done");
      v = $random(seed);
      w = $random(seed);
      gd = $random(seed);
      wb(1, 8'h00, 32'h0007_0002);
      wb(1, 8'h14, v);
      wb(1, 8'h18, w);
      i_peer.run = 1;
      i_peer.send(v[15:0], gd[7:0]);
      repeat (12) @(posedge clk);
      rd(8'h1c, 32'h0002_099b);
      rd(8'h0c, v & 32'hffff);
      rd(8'h1c, 32'h0002_009b);
      i_peer.send(w[15:0], gd[15:8]);
      repeat (12) @(posedge clk);
      i_peer.run = 0;
      rd(8'h1c, 32'h0002_0abb);
      rd(8'h1c, 32'h0002_009b);
      wb(1, 8'h28, 1);
      rd(8'h04, gd[15:8]);
      rd(8'h1c, 32'h0002_00cb);
      wb(1, 8'h2c, 0);
      rd(8'h1c, 32'h0002_008b);
      $display("receive done");
      wb(1, 8'h00, 32'h0007_0000);
      wb(1, 8'h20, 2);
      rd(8'h1c, 32'h0000_0083);
      wb(1, 8'h08, v);
      wb(1, 8'h08, w);
      rd(8'h1c, 32'h0000_008c);
      wb(1, 8'h24, 0);
      rd(8'h1c, 32'h0000_0088);
      $display("counters done");
      conclude;
   end
endmodule // ssd_serial_ctrl_tb
